// *** bench/tapc_chk.sv ***
// Purpose: port-level checks of the test access port block
// Assumes: one mclk domain, rst synchronous active high
// Notes:   bound to tapc_top, sees its ports only
`timescale 1ns/1ps

module tapc_chk (
  input wire logic mclk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic tck, // test clock pin
  input wire logic trst_n, // test reset pin
  input wire logic dev_rst_n, // device reset pin
  input wire logic tdo, // test data output
  input wire logic tdo_oe, // test data output enable
  input wire logic [4:0] pin_digital_enable, // pin digital enables
  input wire logic [4:0] pin_pullup_enable, // pin pull-ups
  input wire logic [4:0] pin_alt_function_select, // pin alt function
  input wire logic mass_erase // erase pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // apb answer comes one cycle after the first access cycle
  sequence first_access;
    psel && penable && !$past(penable);
  endsequence
  sequence late_ready;
    !pready ##1 pready;
  endsequence
  // test clock still, no test reset, data output pin kept on the port
  sequence tck_still;
    trst_n && pin_alt_function_select[3] && $stable(tck);
  endsequence

  apb_answer_a: assert property (first_access |-> late_ready)
    else $error("apb answer out of time");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an answer");
  pin_reset_a: assert property ($fell(rst) |-> (pin_digital_enable == 5'h1F) &&
    (pin_pullup_enable == 5'h1F) && (pin_alt_function_select == 5'h1F))
    else $error("pin fields not one after reset");
  dev_pins_a: assert property (!dev_rst_n [*4] |=> (pin_digital_enable == 5'h1F) &&
    (pin_alt_function_select == 5'h1F)) else $error("device reset left pins");
  trst_quiet_a: assert property ((!trst_n && pin_alt_function_select[4]) [*6] |=>
    !tdo_oe) else $error("tdo driven under test reset");
  oe_alt_a: assert property (tdo_oe |-> pin_alt_function_select[3] ||
    $past(pin_alt_function_select[3], 2)) else $error("tdo driven as gpio");
  tdo_fall_a: assert property (($changed(tdo) && tdo_oe) |-> !$past(tck, 2))
    else $error("tdo moved off the falling edge");
  oe_fall_a: assert property ($rose(tdo_oe) |-> !$past(tck, 2))
    else $error("tdo enable rose off the falling edge");
  static_hold_a: assert property (tck_still [*8] |-> $stable(tdo) && $stable(tdo_oe))
    else $error("output moved with test clock still");
  erase_pulse_a: assert property (mass_erase |=> !mass_erase)
    else $error("erase pulse too long");
  erase_held_a: assert property (mass_erase |-> !$past(dev_rst_n, 4))
    else $error("erase without device reset");
endmodule

bind tapc_top tapc_chk chk_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .tck(tck), .trst_n(trst_n), .dev_rst_n(dev_rst_n),
  .tdo(tdo), .tdo_oe(tdo_oe), .pin_digital_enable(pin_digital_enable),
  .pin_pullup_enable(pin_pullup_enable), .pin_alt_function_select(pin_alt_function_select),
  .mass_erase(mass_erase));

// *** bench/tapc_probe.sv ***
// Purpose: external test probe driving the link pins
// Assumes: paced by mclk, 200 ns link period
// Notes:   test clock stands still between calls
`timescale 1ns/1ps

module tapc_probe (
  input wire logic mclk, // pacing clock
  input wire logic tdo_line, // resolved data line, pulled up
  output logic tck, // test clock
  output logic tms, // mode select
  output logic tdi // test data in
);
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // one link bit: fall with new levels, sample, then rise
  task step(input logic m, input logic d, output logic o);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge mclk);
    o = tdo_line;
    tck <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
endmodule

// *** bench/testbench.sv ***
// Purpose: self-checking bench of the test access port block
// Assumes: apb master and probe driven on mclk rising edges
// Notes:   status compared on its low twelve bits
`timescale 1ns/1ps
`include "tapc_defines.vh"

module testbench;
  logic mclk, rst, psel, penable, pwrite, trst_n, dev_rst_n, se, ob;
  logic pready, pslverr, tdo, tdo_oe, tck, tms, tdi, mass_erase, tdo_line;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, sh;
  logic [4:0] den, pur, afsel;
  int err_count = 0;
  int n_compared = 0;
  int erases = 0;
  int i;

  tapc_top dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .dev_rst_n(dev_rst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_digital_enable(den), .pin_pullup_enable(pur),
    .pin_alt_function_select(afsel), .mass_erase(mass_erase));
  assign tdo_line = tdo_oe ? tdo : 1'b1; // pull-up when released
  tapc_probe probe_u (.mclk(mclk), .tdo_line(tdo_line), .tck(tck), .tms(tms), .tdi(tdi));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (mass_erase === 1'b1) erases <= erases + 1;
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task report_and_stop;
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20) begin
      chk("apb wait", 1, 0);
      report_and_stop;
    end
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(nm, e, (a == `TAPC_OFS_STATUS) ? (rd & 32'h00000FFF) : rd);
  endtask
  task tb(input logic m, input logic d);
    probe_u.step(m, d, ob);
  endtask
  // shift n bits lsb first, leave through update to idle
  task shift(input int n, input logic [31:0] din);
    int k;
    sh = 32'h00000000;
    for (k = 0; k < n; k++) begin
      tb(k == n - 1, din[k]);
      sh[k] = ob;
      if (k == 0) chk("tdo enable in shift", 1, tdo_oe);
    end
    tb(1'b1, 1'b1);
    tb(1'b0, 1'b1);
  endtask
  task load_ir(input logic [3:0] c);
    tb(1, 1);
    tb(1, 1);
    tb(0, 1);
    tb(0, 1);
    shift(4, {28'h0000000, c});
  endtask
  task scan_dr(input int n, input logic [31:0] din);
    tb(1, 1);
    tb(0, 1);
    tb(0, 1);
    shift(n, din);
  endtask
  // mode switch: high run then pattern, trailing run left out
  task swseq(input logic [15:0] pat);
    int k;
    repeat (50) tb(1, 1);
    for (k = 0; k < 16; k++) tb(pat[k], 1);
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    trst_n = 1'b1;
    dev_rst_n = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdc("digital enable", `TAPC_OFS_DEN, 32'h0000001F);
    rdc("pull-up enable", `TAPC_OFS_PUR, 32'h0000001F);
    rdc("alt select", `TAPC_OFS_AFSEL, 32'h0000001F);
    rdc("lock", `TAPC_OFS_LOCK, `TAPC_LOCKED);
    rdc("status", `TAPC_OFS_STATUS, 32'h000000E0);
    apb(1'b0, 8'h40, 32'h00000000);
    chk("unmapped error", 1, se);
    tb(0, 1);
    scan_dr(32, 32'hFFFFFFFF);
    chk("idcode shift", 32'h00000001, sh);
    chk("tdo enable idle", 0, tdo_oe);
    for (i = 0; i < 2; i++) begin
      load_ir(i == 0 ? `TAPC_IR_BYPASS : 4'h5);
      chk("ir capture", 32'h00000001, sh);
      rdc("status ir", `TAPC_OFS_STATUS, i == 0 ? 32'h000000F1 : 32'h00000051);
      scan_dr(4, 32'h0000000A);
      chk("bypass path", 32'h00000004, sh);
    end
    repeat (200) @(posedge mclk);
    rdc("static clock", `TAPC_OFS_STATUS, 32'h00000051);
    repeat (5) tb(1, 1);
    rdc("five highs", `TAPC_OFS_STATUS, 32'h000000E0);
    tb(0, 1);
    load_ir(`TAPC_IR_BYPASS);
    trst_n <= 1'b0;
    tb(0, 1);
    rdc("test reset", `TAPC_OFS_STATUS, 32'h000000E0);
    trst_n <= 1'b1;
    apb(1'b1, `TAPC_OFS_AFSEL, 32'h00000000);
    rdc("locked alt select", `TAPC_OFS_AFSEL, 32'h0000001F);
    apb(1'b1, `TAPC_OFS_LOCK, `TAPC_LOCK_KEY);
    rdc("unlocked", `TAPC_OFS_LOCK, `TAPC_UNLOCKED);
    apb(1'b1, `TAPC_OFS_AFSEL, 32'h00000000);
    rdc("uncommitted alt select", `TAPC_OFS_AFSEL, 32'h0000001F);
    apb(1'b1, `TAPC_OFS_COMMIT, 32'h00000001);
    apb(1'b1, `TAPC_OFS_AFSEL, 32'h00000000);
    rdc("one bit committed", `TAPC_OFS_AFSEL, 32'h0000001E);
    apb(1'b1, `TAPC_OFS_COMMIT, 32'h0000001F);
    apb(1'b1, `TAPC_OFS_AFSEL, 32'h00000000);
    // the write lands at the answering edge; look once it has settled
    @(posedge mclk);
    chk("alt select pins", 32'h00000000, {27'h0000000, afsel});
    tb(0, 1);
    rdc("port detached", `TAPC_OFS_STATUS, 32'h000000E0);
    apb(1'b1, `TAPC_OFS_AFSEL, 32'h0000001F);
    apb(1'b1, `TAPC_OFS_DEN, 32'h00000000);
    apb(1'b1, `TAPC_OFS_LOCK, 32'h00000000);
    rdc("relocked", `TAPC_OFS_LOCK, `TAPC_LOCKED);
    dev_rst_n <= 1'b0;
    // device reset passes two synchroniser stages before the fields reset
    repeat (4) @(posedge mclk);
    rdc("device reset pins", `TAPC_OFS_DEN, 32'h0000001F);
    for (i = 0; i < 3; i++) swseq(i[0] ? `TAPC_SEQ_TO_JTAG : `TAPC_SEQ_TO_SW);
    rdc("partial count", `TAPC_OFS_STATUS, 32'h00000300 | 32'h000000E0);
    dev_rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    apb(1'b0, `TAPC_OFS_STATUS, 32'h00000000);
    chk("count cleared", 32'h00000000, {28'h0000000, rd[11:8]});
    chk("no early erase", 32'h00000000, erases);
    dev_rst_n <= 1'b0;
    for (i = 0; i < 10; i++) swseq(i[0] ? `TAPC_SEQ_TO_JTAG : `TAPC_SEQ_TO_SW);
    repeat (10) @(posedge mclk);
    chk("recovery erase", 32'h00000001, erases);
    dev_rst_n <= 1'b1;
    report_and_stop;
  end
endmodule

// *** hdl/tapc_defines.vh ***
// Purpose: shared constants of the test access port block
// Assumes: included by bare name; definitions only
// Notes:   byte offsets of the word-aligned APB register map
`ifndef TAPC_DEFINES_VH
`define TAPC_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define TAPC_OFS_DEN 8'h00
`define TAPC_OFS_PUR 8'h04
`define TAPC_OFS_AFSEL 8'h08
`define TAPC_OFS_LOCK 8'h0C
`define TAPC_OFS_COMMIT 8'h10
`define TAPC_OFS_STATUS 8'h14

// ----------------------------------------------------------------
// reset values and keys
// ----------------------------------------------------------------
`define TAPC_PINS_RST 5'h1F
`define TAPC_COMMIT_RST 5'h00
`define TAPC_LOCK_KEY 32'h1ACCE551
`define TAPC_LOCKED 32'h00000001
`define TAPC_UNLOCKED 32'h00000000

// ----------------------------------------------------------------
// pin bit positions within the five-bit pin fields
// ----------------------------------------------------------------
`define TAPC_PIN_TCK 0
`define TAPC_PIN_TMS 1
`define TAPC_PIN_TDI 2
`define TAPC_PIN_TDO 3
`define TAPC_PIN_TRST 4

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define TAPC_ST_STATE_LSB 0
`define TAPC_ST_IR_LSB 4
`define TAPC_ST_SWCNT_LSB 8
`define TAPC_ST_LINK_BIT 12

// ----------------------------------------------------------------
// instructions
// ----------------------------------------------------------------
`define TAPC_IR_IDCODE 4'hE
`define TAPC_IR_BYPASS 4'hF
`define TAPC_IR_CAPTURE 4'h1

// ----------------------------------------------------------------
// mode switch sequences and counts
// ----------------------------------------------------------------
`define TAPC_SEQ_TO_SW 16'hE79E
`define TAPC_SEQ_TO_JTAG 16'hE73C
`define TAPC_HI_RUN_MIN 6'h32
`define TAPC_SEQ_TOTAL 4'hA

`endif

// *** hdl/tapc_swseq.v ***
// Purpose: detect debug-mode switch sequences on the mode-select line
// Assumes: step is a one-cycle pulse per test clock rising edge
// Notes:   counts alternating sequences while the device reset is held
`timescale 1ns/1ps
`include "tapc_defines.vh"

module tapc_swseq (
  input wire mclk,        // system clock
  input wire rst,         // synchronous reset, active high
  input wire step,        // test clock rising edge seen
  input wire tms,         // synchronised mode-select level
  input wire hold,        // device reset is being held
  output reg erase,       // one-cycle mass erase request
  output reg [3:0] seq_cnt // completed alternating sequences
);

  reg [5:0] hi_run;
  reg armed;
  reg [3:0] bit_cnt;
  reg [15:0] shreg;

  wire [15:0] pat_now = {tms, shreg[15:1]};
  wire last_bit = step & armed & (bit_cnt == 4'hF);
  wire got_sw = last_bit & (pat_now == `TAPC_SEQ_TO_SW);
  wire got_jtag = last_bit & (pat_now == `TAPC_SEQ_TO_JTAG);

  // ----------------------------------------------------------------
  // high run, pattern capture and sequence counting
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst) begin
      hi_run <= 6'h00;
      armed <= 1'b0;
      bit_cnt <= 4'h0;
      shreg <= 16'h0000;
      seq_cnt <= 4'h0;
      erase <= 1'b0;
    end else begin
      erase <= 1'b0;
      if (step) begin
        // saturating count of consecutive high samples
        if (tms) begin
          hi_run <= (hi_run == `TAPC_HI_RUN_MIN) ? hi_run : hi_run + 6'h01;
        end else begin
          hi_run <= 6'h00;
        end
        if (armed) begin
          shreg <= pat_now;
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hF) begin
            armed <= 1'b0;
          end
        end else if (!tms && hi_run == `TAPC_HI_RUN_MIN) begin
          // first low bit after a long enough high run opens a pattern
          armed <= 1'b1;
          bit_cnt <= 4'h1;
          shreg <= pat_now;
        end
      end
      if (!hold) begin
        seq_cnt <= 4'h0;
      end else if (got_sw || got_jtag) begin
        // even count expects a switch to serial wire, odd back to jtag
        if ((got_sw && !seq_cnt[0]) || (got_jtag && seq_cnt[0])) begin
          if (seq_cnt + 4'h1 == `TAPC_SEQ_TOTAL) begin
            erase <= 1'b1;
            seq_cnt <= 4'h0;
          end else begin
            seq_cnt <= seq_cnt + 4'h1;
          end
        end else begin
          seq_cnt <= got_sw ? 4'h1 : 4'h0;
        end
      end
    end
  end

endmodule

// *** hdl/tapc_top.v ***
// Purpose: boundary-scan test access port with shared-pin configuration
// Assumes: test pins are asynchronous and oversampled by mclk
// Notes:   pin configuration and commit protection sit behind APB
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "tapc_defines.vh"

module tapc_top #(
  parameter [31:0] IDCODE_VALUE = 32'h00000001 // arbitrary identity value
) (
  input wire mclk,                            // system clock, 40 MHz
  input wire rst,                             // power-on reset, sync, high
  input wire psel,                            // apb select
  input wire penable,                         // apb access phase
  input wire pwrite,                          // apb write direction
  input wire [7:0] paddr,                     // apb byte address
  input wire [31:0] pwdata,                   // apb write data
  output reg [31:0] prdata,                   // apb read data
  output reg pready,                          // apb ready
  output reg pslverr,                         // apb error, unmapped address
  input wire tck,                             // test clock pin
  input wire tms,                             // mode-select pin
  input wire tdi,                             // test data input pin
  input wire trst_n,                          // test reset pin, active low
  input wire dev_rst_n,                       // device reset pin, active low
  output reg tdo,                             // test data output
  output reg tdo_oe,                          // test data output enable
  output reg [4:0] pin_digital_enable,        // debug pin digital enables
  output reg [4:0] pin_pullup_enable,         // debug pin pull-ups
  output reg [4:0] pin_alt_function_select,   // debug pin alt function
  output reg mass_erase                       // whole flash erase request pulse
);

  // ----------------------------------------------------------------
  // controller states
  // ----------------------------------------------------------------
  localparam [3:0] ST_TLR = 4'h0;
  localparam [3:0] ST_RTI = 4'h1;
  localparam [3:0] ST_SELDR = 4'h2;
  localparam [3:0] ST_CAPDR = 4'h3;
  localparam [3:0] ST_SHDR = 4'h4;
  localparam [3:0] ST_EX1DR = 4'h5;
  localparam [3:0] ST_PSDR = 4'h6;
  localparam [3:0] ST_EX2DR = 4'h7;
  localparam [3:0] ST_UPDR = 4'h8;
  localparam [3:0] ST_SELIR = 4'h9;
  localparam [3:0] ST_CAPIR = 4'hA;
  localparam [3:0] ST_SHIR = 4'hB;
  localparam [3:0] ST_EX1IR = 4'hC;
  localparam [3:0] ST_PSIR = 4'hD;
  localparam [3:0] ST_EX2IR = 4'hE;
  localparam [3:0] ST_UPIR = 4'hF;

  // next controller state from current state and sampled mode-select
  function [3:0] tapc_next;
    input [3:0] st;
    input m;
    begin
      case (st)
        ST_TLR: tapc_next = m ? ST_TLR : ST_RTI;
        ST_RTI: tapc_next = m ? ST_SELDR : ST_RTI;
        ST_SELDR: tapc_next = m ? ST_SELIR : ST_CAPDR;
        ST_CAPDR: tapc_next = m ? ST_EX1DR : ST_SHDR;
        ST_SHDR: tapc_next = m ? ST_EX1DR : ST_SHDR;
        ST_EX1DR: tapc_next = m ? ST_UPDR : ST_PSDR;
        ST_PSDR: tapc_next = m ? ST_EX2DR : ST_PSDR;
        ST_EX2DR: tapc_next = m ? ST_UPDR : ST_SHDR;
        ST_UPDR: tapc_next = m ? ST_SELDR : ST_RTI;
        ST_SELIR: tapc_next = m ? ST_TLR : ST_CAPIR;
        ST_CAPIR: tapc_next = m ? ST_EX1IR : ST_SHIR;
        ST_SHIR: tapc_next = m ? ST_EX1IR : ST_SHIR;
        ST_EX1IR: tapc_next = m ? ST_UPIR : ST_PSIR;
        ST_PSIR: tapc_next = m ? ST_EX2IR : ST_PSIR;
        ST_EX2IR: tapc_next = m ? ST_UPIR : ST_SHIR;
        ST_UPIR: tapc_next = m ? ST_SELDR : ST_RTI;
        default: tapc_next = ST_TLR;
      endcase
    end
  endfunction

  // instruction decode: only the id code selects the long chain
  function sel_id;
    input [3:0] code;
    begin
      sel_id = (code == `TAPC_IR_IDCODE);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers and test clock edge detection
  // ----------------------------------------------------------------
  reg tck_m, tck_s, tck_d;
  reg tms_m, tms_s;
  reg tdi_m, tdi_s;
  reg trst_m, trst_s;
  reg drst_m, drst_s;

  // two flip-flops per pin before any logic reads it
  always @(posedge mclk) begin
    if (rst) begin
      {tck_m, tck_s, tck_d} <= 3'h7;
      {tms_m, tms_s, tdi_m, tdi_s} <= 4'hF;
      {trst_m, trst_s, drst_m, drst_s} <= 4'hF;
    end else begin
      tck_m <= tck;
      tck_s <= tck_m;
      tck_d <= tck_s;
      tms_m <= tms;
      tms_s <= tms_m;
      tdi_m <= tdi;
      tdi_s <= tdi_m;
      trst_m <= trst_n;
      trst_s <= trst_m;
      drst_m <= dev_rst_n;
      drst_s <= drst_m;
    end
  end

  // port only listens while its input pins keep the debug function
  wire link_on = pin_alt_function_select[`TAPC_PIN_TCK] &
                 pin_alt_function_select[`TAPC_PIN_TMS] &
                 pin_alt_function_select[`TAPC_PIN_TDI];
  wire tck_rise = link_on & tck_s & ~tck_d;
  wire tck_fall = link_on & ~tck_s & tck_d;
  wire trst_act = pin_alt_function_select[`TAPC_PIN_TRST] & ~trst_s;
  wire dev_hold = ~drst_s;

  // ----------------------------------------------------------------
  // controller, instruction chain and data chains
  // ----------------------------------------------------------------
  reg [3:0] state;
  reg [3:0] ir;
  reg [3:0] ir_sh;
  reg [31:0] dr_sh;
  wire [3:0] next_state = tapc_next(state, tms_s);

  // all actions except test reset happen only on a detected rising test clock edge
  always @(posedge mclk) begin
    if (rst || trst_act) begin
      state <= ST_TLR;
      ir <= `TAPC_IR_IDCODE;
      ir_sh <= `TAPC_IR_CAPTURE;
      dr_sh <= 32'h00000000;
    end else if (tck_rise) begin
      state <= next_state;
      case (state)
        ST_CAPIR: begin
          ir_sh <= `TAPC_IR_CAPTURE;
        end
        ST_SHIR: begin
          ir_sh <= {tdi_s, ir_sh[3:1]};
        end
        ST_UPIR: begin
          ir <= ir_sh;
        end
        ST_CAPDR: begin
          // every code other than id code acts as the one-bit bypass
          if (sel_id(ir)) begin
            dr_sh <= IDCODE_VALUE;
          end else begin
            dr_sh <= 32'h00000000;
          end
        end
        ST_SHDR: begin
          if (sel_id(ir)) begin
            dr_sh <= {tdi_s, dr_sh[31:1]};
          end else begin
            dr_sh <= {31'h00000000, tdi_s};
          end
        end
        default: begin
          ir <= ir;
        end
      endcase
      // id instruction loads on the edge that enters test-logic-reset
      if (next_state == ST_TLR) begin
        ir <= `TAPC_IR_IDCODE;
      end
    end
  end

  // data output and its enable move on the falling test clock edge
  always @(posedge mclk) begin
    if (rst || trst_act || !pin_alt_function_select[`TAPC_PIN_TDO]) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= (state == ST_SHIR) ? ir_sh[0] : dr_sh[0];
      tdo_oe <= (state == ST_SHIR) || (state == ST_SHDR);
    end
  end

  // ----------------------------------------------------------------
  // recovery sequence detector
  // ----------------------------------------------------------------
  wire erase_req;
  wire [3:0] seq_cnt;

  tapc_swseq u_swseq (
    .mclk(mclk),
    .rst(rst),
    .step(tck_rise),
    .tms(tms_s),
    .hold(dev_hold),
    .erase(erase_req),
    .seq_cnt(seq_cnt)
  );

  // erase covers the whole array; protection and nv words untouched
  always @(posedge mclk) begin
    if (rst) begin
      mass_erase <= 1'b0;
    end else begin
      mass_erase <= erase_req;
    end
  end

  // ----------------------------------------------------------------
  // apb slave and pin configuration registers
  // ----------------------------------------------------------------
  reg unlocked;
  reg [4:0] commit;
  wire cfg_rst = rst | dev_hold;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire [4:0] af_mask = commit & {5{unlocked}};
  reg mapped;
  reg [31:0] rd_val;

  // read mux and address decode
  always @* begin
    mapped = 1'b1;
    rd_val = 32'h00000000;
    case (paddr)
      `TAPC_OFS_DEN: rd_val = {27'h0000000, pin_digital_enable};
      `TAPC_OFS_PUR: rd_val = {27'h0000000, pin_pullup_enable};
      `TAPC_OFS_AFSEL: rd_val = {27'h0000000, pin_alt_function_select};
      `TAPC_OFS_LOCK: rd_val = unlocked ? `TAPC_UNLOCKED : `TAPC_LOCKED;
      `TAPC_OFS_COMMIT: rd_val = {27'h0000000, commit};
      `TAPC_OFS_STATUS: begin
        rd_val[`TAPC_ST_STATE_LSB +: 4] = state;
        rd_val[`TAPC_ST_IR_LSB +: 4] = ir;
        rd_val[`TAPC_ST_SWCNT_LSB +: 4] = seq_cnt;
        rd_val[`TAPC_ST_LINK_BIT] = link_on;
      end
      default: mapped = 1'b0;
    endcase
  end

  // ready one cycle into the access phase; data and error with it
  always @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // configuration held at defaults under power-on or device reset
  always @(posedge mclk) begin
    if (cfg_rst) begin
      pin_digital_enable <= `TAPC_PINS_RST;
      pin_pullup_enable <= `TAPC_PINS_RST;
      pin_alt_function_select <= `TAPC_PINS_RST;
      unlocked <= 1'b0;
      commit <= `TAPC_COMMIT_RST;
    end else if (wr) begin
      case (paddr)
        `TAPC_OFS_DEN: pin_digital_enable <= pwdata[4:0];
        `TAPC_OFS_PUR: pin_pullup_enable <= pwdata[4:0];
        `TAPC_OFS_AFSEL: begin
          // only unlocked and committed bits take the new value
          pin_alt_function_select <= (pin_alt_function_select & ~af_mask) |
                                     (pwdata[4:0] & af_mask);
        end
        `TAPC_OFS_LOCK: unlocked <= (pwdata == `TAPC_LOCK_KEY);
        `TAPC_OFS_COMMIT: begin
          if (unlocked) begin
            commit <= pwdata[4:0];
          end
        end
        default: commit <= commit;
      endcase
    end
  end

endmodule
